// ===== src/async_timer2.sv
// Implementation choices: the address map and strobed register access.
`timescale 1ns/10ps
`include "async_timer2_regs.svh"

// What this block does
// - Clock select zero counts on clk_i; one counts on crystal input rising edges.
// - Changing clock select cancels pending transfers; register contents are not guaranteed.
// - Async counter write sets count pending; cleared when counter loads from temp.
// - Async compare write sets compare pending bit 1; cleared after transfer.
// - Async control write sets control pending bit 0; cleared after transfer.
// - Counter reads return the read-back register; compare and control reads return temp storage.
// - Async writes land in temp and transfer after two rising crystal edges.
// - Each of the three registers has its own temp register and transfer path.
// - While compare or counter write is in transfer, compare match is suppressed.
// - After a wake-up, two crystal cycles pass before another wake-up can occur.
// - Wake-up starts on the timer clock after the interrupt condition.
// - Counter read-back register refreshes on crystal edges when async, every clk_i when sync; frozen in power-save.
// - Flag sync takes one timer cycle plus three processor cycles when async.
// - Compare output pin changes on timer clock, not resynchronised.
// - Compare enable bit 7 and global enable with compare flag request interrupt.
// - Overflow enable bit 6 and global enable with overflow flag request interrupt.
// - Compare flag sets on match; clears on vector execution or written one.
// - Overflow flag sets on overflow; clears on vector execution or written one.
// - In phase correct PWM overflow flag sets when counting turns at zero.
module async_timer2
  import async_timer2_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Register port
  input wire reg_req_t reg_req_i,
  output logic [7:0] rdata_o,
  // Crystal pin
  input wire logic crystal_osc_input_i,
  // CPU side
  input wire logic global_irq_enable_i,
  input wire logic compare_vector_ack_i,
  input wire logic overflow_vector_ack_i,
  input wire logic power_save_i,
  // Requests and pin
  output logic compare_irq_o,
  output logic overflow_irq_o,
  output logic wakeup_o,
  output logic compare_out_o
);

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  function automatic logic is_write(input reg_req_t req, input logic [2:0] ofs);
    is_write = req.wr && (req.addr == ofs);
  endfunction : is_write

  function automatic logic [2:0] slot_offset(input int idx);
    case (idx)
      0: slot_offset = `OFS_COUNTER_VALUE;
      1: slot_offset = `OFS_COMPARE_VALUE;
      default: slot_offset = `OFS_TIMER_CONTROL;
    endcase
  endfunction : slot_offset

  // ----------------------------------------
  // Crystal pin synchroniser and edge
  // ----------------------------------------
  logic xtal_meta_reg;
  logic xtal_sync_reg;
  logic xtal_prev_reg;
  logic xtal_rise;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      xtal_meta_reg <= 1'b0;
      xtal_sync_reg <= 1'b0;
      xtal_prev_reg <= 1'b0;
    end else begin
      xtal_meta_reg <= crystal_osc_input_i;
      xtal_sync_reg <= xtal_meta_reg;
      xtal_prev_reg <= xtal_sync_reg;
    end
  end

  // Edge is only reliable when clk_i runs well above the crystal
  assign xtal_rise = xtal_sync_reg & ~xtal_prev_reg;

  // ----------------------------------------
  // Clock select
  // ----------------------------------------
  logic async_clock_select_reg;
  logic select_change;
  logic timer_tick;

  assign select_change = is_write(reg_req_i, `OFS_ASYNC_STATUS) &&
                         (reg_req_i.wdata[`BIT_ASYNC_SELECT] != async_clock_select_reg);

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      async_clock_select_reg <= 1'b0;
    end else if (is_write(reg_req_i, `OFS_ASYNC_STATUS)) begin
      async_clock_select_reg <= reg_req_i.wdata[`BIT_ASYNC_SELECT];
    end
  end

  assign timer_tick = async_clock_select_reg ? xtal_rise : 1'b1;

  // ----------------------------------------
  // Temp registers and transfer paths
  // ----------------------------------------
  logic [7:0] temp_reg [3];
  logic [7:0] dest_reg [3];
  logic [2:0] pending_reg;
  logic [2:0] load_now;
  logic [1:0] edge_cnt_reg [3];

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_slot
      logic wr_hit;
      logic [7:0] wr_val;
      assign wr_hit = is_write(reg_req_i, slot_offset(gi));
      // Force-compare strobe is never stored
      assign wr_val = (gi == SLOT_CONTROL) ?
                      (reg_req_i.wdata & 8'h7F) : reg_req_i.wdata;
      assign load_now[gi] = pending_reg[gi] && xtal_rise &&
                            (edge_cnt_reg[gi] == `TRANSFER_EDGES - 2'h1);

      always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          temp_reg[gi] <= `RST_BYTE;
          pending_reg[gi] <= 1'b0;
          edge_cnt_reg[gi] <= 2'h0;
        end else if (select_change) begin
          pending_reg[gi] <= 1'b0;
          edge_cnt_reg[gi] <= 2'h0;
        end else if (wr_hit) begin
          temp_reg[gi] <= wr_val;
          pending_reg[gi] <= async_clock_select_reg;
          edge_cnt_reg[gi] <= 2'h0;
        end else if (load_now[gi]) begin
          pending_reg[gi] <= 1'b0;
          edge_cnt_reg[gi] <= 2'h0;
        end else if (pending_reg[gi] && xtal_rise) begin
          edge_cnt_reg[gi] <= edge_cnt_reg[gi] + 2'h1;
        end
      end

      if (gi != SLOT_COUNT) begin : g_dest
        always_ff @(posedge clk_i or negedge resetn_i) begin
          if (!resetn_i) begin
            dest_reg[gi] <= `RST_BYTE;
          end else if (wr_hit && !async_clock_select_reg) begin
            dest_reg[gi] <= wr_val;
          end else if (load_now[gi]) begin
            dest_reg[gi] <= temp_reg[gi];
          end
        end
      end else begin : g_nodest
        assign dest_reg[gi] = `RST_BYTE;
      end
    end
  endgenerate

  // ----------------------------------------
  // Counter core
  // ----------------------------------------
  logic [7:0] count_reg;
  logic [7:0] compare_live;
  logic [7:0] control_live;
  logic running;
  logic pwm_mode;
  logic ctc_mode;
  logic match_hit;
  logic match_allowed;
  logic overflow_hit;
  count_dir_t dir_reg;

  assign compare_live = dest_reg[SLOT_COMPARE];
  assign control_live = dest_reg[SLOT_CONTROL];
  assign running = control_live[2:0] != 3'h0;
  assign pwm_mode = control_live[`BIT_WGM_PWM];
  assign ctc_mode = control_live[`BIT_WGM_CTC];
  // Match would fire on a half-loaded value, so hold it off
  assign match_allowed = ~pending_reg[SLOT_COUNT] & ~pending_reg[SLOT_COMPARE];
  assign match_hit = timer_tick && running && match_allowed && (count_reg == compare_live);

  always_comb begin
    overflow_hit = 1'b0;
    if (timer_tick && running) begin
      if (pwm_mode && !ctc_mode) begin
        overflow_hit = (dir_reg == DIR_DOWN) && (count_reg == `COUNT_BOTTOM + 8'h1);
      end else begin
        overflow_hit = count_reg == `COUNT_MAX;
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      count_reg <= `RST_BYTE;
      dir_reg <= DIR_UP;
    end else if (is_write(reg_req_i, `OFS_COUNTER_VALUE) && !async_clock_select_reg) begin
      count_reg <= reg_req_i.wdata;
    end else if (load_now[SLOT_COUNT]) begin
      count_reg <= temp_reg[SLOT_COUNT];
    end else if (timer_tick && running) begin
      if (pwm_mode && !ctc_mode) begin
        case (dir_reg)
          DIR_UP: begin
            if (count_reg == `COUNT_MAX) begin
              dir_reg <= DIR_DOWN;
              count_reg <= count_reg - 8'h1;
            end else begin
              count_reg <= count_reg + 8'h1;
            end
          end
          DIR_DOWN: begin
            if (count_reg == `COUNT_BOTTOM + 8'h1) begin
              dir_reg <= DIR_UP;
            end
            count_reg <= count_reg - 8'h1;
          end
          default: dir_reg <= DIR_UP;
        endcase
      end else if (ctc_mode && !pwm_mode && match_hit) begin
        count_reg <= `COUNT_BOTTOM;
        dir_reg <= DIR_UP;
      end else begin
        count_reg <= count_reg + 8'h1;
        dir_reg <= DIR_UP;
      end
    end
  end

  // ----------------------------------------
  // Compare output pin, timer clock only
  // ----------------------------------------
  logic [1:0] com_bits;
  assign com_bits = {control_live[`BIT_COM_HI], control_live[`BIT_COM_LO]};

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      compare_out_o <= 1'b0;
    end else if (match_hit) begin
      case (com_bits)
        2'b01: compare_out_o <= (pwm_mode || ctc_mode) && pwm_mode ? compare_out_o : ~compare_out_o;
        2'b10: compare_out_o <= (pwm_mode && !ctc_mode) ? (dir_reg == DIR_DOWN) : 1'b0;
        2'b11: compare_out_o <= (pwm_mode && !ctc_mode) ? (dir_reg == DIR_UP) : 1'b1;
        default: compare_out_o <= compare_out_o;
      endcase
    end else if (timer_tick && running && pwm_mode && ctc_mode && count_reg == `COUNT_MAX) begin
      compare_out_o <= (com_bits == 2'b10);
    end
  end

  // ----------------------------------------
  // Counter read-back register
  // ----------------------------------------
  logic [7:0] count_shadow_reg;
  logic tick_seen_reg;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tick_seen_reg <= 1'b0;
      count_shadow_reg <= `RST_BYTE;
    end else begin
      tick_seen_reg <= xtal_rise;
      if (power_save_i) begin
        count_shadow_reg <= count_shadow_reg;
      end else if (!async_clock_select_reg || tick_seen_reg) begin
        count_shadow_reg <= count_reg;
      end
    end
  end

  // ----------------------------------------
  // Event sync into processor domain
  // ----------------------------------------
  logic [1:0] event_hold_reg;
  logic [1:0] event_ready;
  logic [1:0] event_pipe_reg [`FLAG_SYNC_CYCLES];

  // One timer cycle of latency when async, none when synchronous
  assign event_ready = async_clock_select_reg ? (event_hold_reg & {2{xtal_rise}}) :
                       {match_hit, overflow_hit};

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      event_hold_reg <= 2'b00;
    end else if (async_clock_select_reg) begin
      event_hold_reg <= (event_hold_reg & ~{2{xtal_rise}}) | {match_hit, overflow_hit};
    end else begin
      event_hold_reg <= 2'b00;
    end
  end

  generate
    for (gi = 0; gi < `FLAG_SYNC_CYCLES; gi++) begin : g_pipe
      // Clamped so stage 0 never names index -1
      localparam int prev_idx = (gi == 0) ? 0 : gi - 1;
      always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          event_pipe_reg[gi] <= 2'b00;
        end else if (gi == 0) begin
          event_pipe_reg[gi] <= event_ready;
        end else begin
          event_pipe_reg[gi] <= event_pipe_reg[prev_idx];
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Flags and mask
  // ----------------------------------------
  logic compare_match_flag_reg;
  logic overflow_flag_reg;
  logic compare_irq_enable_reg;
  logic overflow_irq_enable_reg;
  logic [1:0] flag_set;
  logic flag_wr;

  assign flag_set = event_pipe_reg[`FLAG_SYNC_CYCLES - 1];
  assign flag_wr = is_write(reg_req_i, `OFS_IRQ_FLAGS);

  // Set beats a clear arriving in the same cycle
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      compare_match_flag_reg <= 1'b0;
    end else if (flag_set[1]) begin
      compare_match_flag_reg <= 1'b1;
    end else if (compare_vector_ack_i || (flag_wr && reg_req_i.wdata[`BIT_COMPARE_IRQ])) begin
      compare_match_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      overflow_flag_reg <= 1'b0;
    end else if (flag_set[0]) begin
      overflow_flag_reg <= 1'b1;
    end else if (overflow_vector_ack_i || (flag_wr && reg_req_i.wdata[`BIT_OVERFLOW_IRQ])) begin
      overflow_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      compare_irq_enable_reg <= 1'b0;
      overflow_irq_enable_reg <= 1'b0;
    end else if (is_write(reg_req_i, `OFS_IRQ_MASK)) begin
      compare_irq_enable_reg <= reg_req_i.wdata[`BIT_COMPARE_IRQ];
      overflow_irq_enable_reg <= reg_req_i.wdata[`BIT_OVERFLOW_IRQ];
    end
  end

  assign compare_irq_o = compare_match_flag_reg & compare_irq_enable_reg & global_irq_enable_i;
  assign overflow_irq_o = overflow_flag_reg & overflow_irq_enable_reg & global_irq_enable_i;

  // ----------------------------------------
  // Power-save wake-up
  // ----------------------------------------
  logic wake_block_reg;
  logic wake_cond;

  assign wake_cond = power_save_i && async_clock_select_reg && (compare_irq_o || overflow_irq_o);

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wakeup_o <= 1'b0;
      wake_block_reg <= 1'b0;
    end else begin
      wakeup_o <= wake_cond && xtal_rise && !wake_block_reg;
      if (wake_cond && xtal_rise && !wake_block_reg) begin
        wake_block_reg <= 1'b1;
      end else if (xtal_rise) begin
        wake_block_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_o <= `RST_BYTE;
    end else if (reg_req_i.rd) begin
      case (reg_req_i.addr)
        `OFS_COUNTER_VALUE: rdata_o <= count_shadow_reg;
        `OFS_COMPARE_VALUE: rdata_o <= temp_reg[SLOT_COMPARE];
        `OFS_TIMER_CONTROL: rdata_o <= temp_reg[SLOT_CONTROL];
        `OFS_ASYNC_STATUS: rdata_o <= {4'h0, async_clock_select_reg, pending_reg[SLOT_COUNT],
                                       pending_reg[SLOT_COMPARE], pending_reg[SLOT_CONTROL]};
        `OFS_IRQ_MASK: rdata_o <= {compare_irq_enable_reg, overflow_irq_enable_reg, 6'h00};
        `OFS_IRQ_FLAGS: rdata_o <= {compare_match_flag_reg, overflow_flag_reg, 6'h00};
        default: rdata_o <= `RST_BYTE;
      endcase
    end else begin
      rdata_o <= `RST_BYTE;
    end
  end

endmodule : async_timer2

// ===== include/async_timer2_regs.svh
`ifndef ASYNC_TIMER2_REGS_SVH
`define ASYNC_TIMER2_REGS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_COUNTER_VALUE 3'h0
`define OFS_COMPARE_VALUE 3'h1
`define OFS_TIMER_CONTROL 3'h2
`define OFS_ASYNC_STATUS 3'h3
`define OFS_IRQ_MASK 3'h4
`define OFS_IRQ_FLAGS 3'h5

// ----------------------------------------
// Field positions
// ----------------------------------------
`define BIT_ASYNC_SELECT 3
`define BIT_COUNT_PENDING 2
`define BIT_COMPARE_PENDING 1
`define BIT_CONTROL_PENDING 0
`define BIT_COMPARE_IRQ 7
`define BIT_OVERFLOW_IRQ 6
`define BIT_FORCE_COMPARE 7
`define BIT_WGM_PWM 6
`define BIT_WGM_CTC 3
`define BIT_COM_HI 5
`define BIT_COM_LO 4

// ----------------------------------------
// Reset values and timing counts
// ----------------------------------------
`define RST_BYTE 8'h00
`define COUNT_MAX 8'hFF
`define COUNT_BOTTOM 8'h00
`define TRANSFER_EDGES 2'h2
`define FLAG_SYNC_CYCLES 3

`endif

// ===== include/async_timer2_pkg.sv
package async_timer2_pkg;

  // Register port request
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  // Counting direction
  typedef enum logic {
    DIR_UP,
    DIR_DOWN
  } count_dir_t;

  // Index of the three buffered registers
  typedef enum logic [1:0] {
    SLOT_COUNT,
    SLOT_COMPARE,
    SLOT_CONTROL
  } slot_t;

endpackage : async_timer2_pkg

// ===== sim/async_timer2_asserts.sv
`timescale 1ns/10ps
module async_timer2_asserts
  import async_timer2_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Register port
  input wire reg_req_t reg_req_i,
  input wire logic [7:0] rdata_o,
  // Pins and CPU side
  input wire logic crystal_osc_input_i,
  input wire logic global_irq_enable_i,
  input wire logic compare_vector_ack_i,
  input wire logic overflow_vector_ack_i,
  input wire logic power_save_i,
  input wire logic compare_irq_o,
  input wire logic overflow_irq_o,
  input wire logic wakeup_o,
  input wire logic compare_out_o
);
  logic [7:0] mask_reg;
  logic sel_reg;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // ----------------------------------------
  // Shadows of bus-written settings
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mask_reg <= 8'h00;
      sel_reg <= 1'b0;
    end else if (reg_req_i.wr) begin
      if (reg_req_i.addr == 3'h4) mask_reg <= reg_req_i.wdata;
      if (reg_req_i.addr == 3'h3) sel_reg <= reg_req_i.wdata[3];
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  a_cmp_irq_gate: assert property (compare_irq_o |-> mask_reg[7] && global_irq_enable_i)
    else $error("compare request without enables");
  a_ovf_irq_gate: assert property (overflow_irq_o |-> mask_reg[6] && global_irq_enable_i)
    else $error("overflow request without enables");
  a_rdata_idle: assert property (!$past(reg_req_i.rd) |-> rdata_o == 8'h00)
    else $error("read data outside read slot");
  a_wake_single: assert property (wakeup_o |=> !wakeup_o [*3])
    else $error("wake pulse repeated too soon");
  a_wake_in_sleep: assert property (wakeup_o |-> $past(power_save_i))
    else $error("wake pulse outside power save");
  a_wake_needs_irq: assert property (wakeup_o |-> $past(compare_irq_o) || $past(overflow_irq_o))
    else $error("wake pulse without request");
  a_status_select: assert property (reg_req_i.rd && reg_req_i.addr == 3'h3
    |=> rdata_o[3] == sel_reg && rdata_o[7:4] == 4'h0)
    else $error("status select bit wrong");
  a_sync_no_pend: assert property (reg_req_i.rd && reg_req_i.addr == 3'h3 && !sel_reg
    |=> rdata_o[2:0] == 3'h0)
    else $error("pending flag set in sync mode");
  a_ctrl_top_zero: assert property (reg_req_i.rd && reg_req_i.addr == 3'h2 |=> !rdata_o[7])
    else $error("control bit 7 reads one");
  c_wake: cover property (wakeup_o);
  c_cmp_irq: cover property (compare_irq_o);
  c_ovf_irq: cover property (overflow_irq_o);
endmodule : async_timer2_asserts

bind async_timer2 async_timer2_asserts u_async_timer2_asserts (
  .clk_i(clk_i), .resetn_i(resetn_i), .reg_req_i(reg_req_i), .rdata_o(rdata_o),
  .crystal_osc_input_i(crystal_osc_input_i), .global_irq_enable_i(global_irq_enable_i),
  .compare_vector_ack_i(compare_vector_ack_i), .overflow_vector_ack_i(overflow_vector_ack_i),
  .power_save_i(power_save_i), .compare_irq_o(compare_irq_o), .overflow_irq_o(overflow_irq_o),
  .wakeup_o(wakeup_o), .compare_out_o(compare_out_o)
);

// ===== sim/async_timer2_tb.sv
`timescale 1ns/10ps
module async_timer2_tb;
  import async_timer2_pkg::*;
  logic clk_i, resetn_i, xtal, gie, cack, oack, psave, xt_run;
  reg_req_t req;
  logic [7:0] rdata;
  logic cirq, oirq, wake, cout;
  int errors, tests_run, cyc, xt_cnt;

  async_timer2 u_async_timer2 (
    .clk_i(clk_i), .resetn_i(resetn_i), .reg_req_i(req), .rdata_o(rdata),
    .crystal_osc_input_i(xtal), .global_irq_enable_i(gie), .compare_vector_ack_i(cack),
    .overflow_vector_ack_i(oack), .power_save_i(psave), .compare_irq_o(cirq),
    .overflow_irq_o(oirq), .wakeup_o(wake), .compare_out_o(cout)
  );

  always #12.5 clk_i = ~clk_i;
  // Crystal period of 12 clocks keeps the clock ratio above four
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      wrap_up();
    end
    if (xt_run) begin
      xt_cnt <= (xt_cnt == 5) ? 0 : xt_cnt + 1;
      if (xt_cnt == 5) xtal <= ~xtal;
    end
  end
  // ----------------------------------------
  // Bus and compare helpers
  // ----------------------------------------
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_i);
    req.wr <= 1'b0;
    @(posedge clk_i);
  endtask : wr
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk_i);
    req.rd <= 1'b0;
    #1 d = rdata;
    @(posedge clk_i);
  endtask : rd
  task automatic rchk(input logic [2:0] a, input logic [7:0] e, input string what);
    logic [7:0] d;
    rd(a, d);
    chk(what, e, d);
  endtask : rchk
  task automatic pend_wait;
    logic [7:0] s;
    int n;
    n = 0;
    s = 8'hFF;
    while (s !== 8'h08 && n < 20) begin
      rd(3'h3, s);
      n++;
    end
    chk("status idle", 8'h08, s);
  endtask : pend_wait
  task automatic bit_at_neg(input string what, input logic e, ref logic s);
    @(negedge clk_i);
    chk(what, {7'h0, e}, {7'h0, s});
    @(posedge clk_i);
  endtask : bit_at_neg
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs;
    for (int i = 0; i < 8; i++) rchk(i[2:0], 8'h00, "reset value");
    wr(3'h6, 8'hFF);
    wr(3'h7, 8'hFF);
    rchk(3'h6, 8'h00, "unmapped");
    wr(3'h1, 8'h5A);
    rchk(3'h1, 8'h5A, "compare");
    wr(3'h2, 8'h80);
    rchk(3'h2, 8'h00, "control");
    wr(3'h0, 8'h33);
    rchk(3'h0, 8'h33, "count sync");
    rchk(3'h3, 8'h00, "status sync");
  endtask : t_regs
  task automatic t_async;
    wr(3'h3, 8'h0F);
    rchk(3'h3, 8'h08, "pending read-only");
    wr(3'h0, 8'h10);
    wr(3'h1, 8'h20);
    wr(3'h2, 8'h00);
    rchk(3'h3, 8'h0F, "all pending");
    pend_wait();
    rchk(3'h1, 8'h20, "compare temp");
    repeat (14) @(posedge clk_i);
    rchk(3'h0, 8'h10, "count loaded");
  endtask : t_async
  task automatic t_flags;
    logic [7:0] a, b;
    int n;
    wr(3'h4, 8'hC0);
    gie <= 1'b1;
    wr(3'h0, 8'hFD);
    pend_wait();
    wr(3'h2, 8'h01);
    pend_wait();
    n = 0;
    while (oirq !== 1'b1 && n < 200) begin @(negedge clk_i); n++; end
    chk("overflow irq", 8'h01, {7'h0, oirq});
    @(posedge clk_i);
    rchk(3'h5, 8'h40, "flags ovf");
    wr(3'h4, 8'h80);
    bit_at_neg("ovf masked", 1'b0, oirq);
    wr(3'h4, 8'hC0);
    bit_at_neg("ovf unmasked", 1'b1, oirq);
    gie <= 1'b0;
    bit_at_neg("ovf global off", 1'b0, oirq);
    gie <= 1'b1;
    oack <= 1'b1;
    @(posedge clk_i);
    oack <= 1'b0;
    bit_at_neg("ovf vector clear", 1'b0, oirq);
    n = 0;
    while (cirq !== 1'b1 && n < 600) begin @(negedge clk_i); n++; end
    chk("compare irq", 8'h01, {7'h0, cirq});
    @(posedge clk_i);
    rchk(3'h5, 8'h80, "flags cmp");
    psave <= 1'b1;
    n = 0;
    while (wake !== 1'b1 && n < 40) begin @(negedge clk_i); n++; end
    chk("wake pulse", 8'h01, {7'h0, wake});
    @(posedge clk_i);
    rd(3'h0, a);
    repeat (20) @(posedge clk_i);
    rd(3'h0, b);
    chk("frozen count", a, b);
    psave <= 1'b0;
    wr(3'h5, 8'h80);
    bit_at_neg("cmp write clear", 1'b0, cirq);
  endtask : t_flags
  task automatic t_switch;
    gie <= 1'b0;
    wr(3'h4, 8'h00);
    wr(3'h3, 8'h00);
    wr(3'h2, 8'h00);
    wr(3'h0, 8'h40);
    rchk(3'h0, 8'h40, "count after switch");
    rchk(3'h3, 8'h00, "status sync again");
    wr(3'h5, 8'hC0);
    rchk(3'h5, 8'h00, "flags cleared");
  endtask : t_switch
  // Pin toggles in normal mode, then clear-on-match keeps the count at or below compare
  task automatic t_pin;
    logic [7:0] d;
    wr(3'h1, 8'h05);
    wr(3'h0, 8'h00);
    wr(3'h2, 8'h11);
    repeat (10) @(posedge clk_i);
    bit_at_neg("compare pin", 1'b1, cout);
    wr(3'h2, 8'h00);
    wr(3'h0, 8'h00);
    wr(3'h2, 8'h19);
    repeat (40) @(posedge clk_i);
    wr(3'h2, 8'h00);
    rd(3'h0, d);
    chk("ctc wrap", 8'h01, {7'h0, d <= 8'h05});
    rchk(3'h5, 8'h80, "ctc flag");
    cack <= 1'b1;
    @(posedge clk_i);
    cack <= 1'b0;
    rchk(3'h5, 8'h00, "cmp vector clear");
  endtask : t_pin
  task automatic wrap_up;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrap_up

  initial begin
    clk_i = 1'b0;
    resetn_i = 1'b0;
    req = '0;
    {xtal, gie, cack, oack, psave} = 5'h00;
    xt_run = 1'b1;
    xt_cnt = 0;
    cyc = 0;
    errors = 0;
    tests_run = 0;
    repeat (10) @(posedge clk_i);
    resetn_i <= 1'b1;
    @(posedge clk_i);
    t_regs();
    t_async();
    t_flags();
    t_switch();
    t_pin();
    wrap_up();
  end
endmodule : async_timer2_tb
